// file: design/hco_pkg.sv
// Constants, types and register map of the hardware cursor overlay
// How it works
// R1: Code 00 passes pixel, 01 inverts, 10 first colour, 11 second colour.
// R2: Image word holds sixteen 2-bit pixels, pixel 0 in lowest bit pair.
// R3: Image lines are fetched by own bus master, one line at a time.
// R4: Overlay starts where pixel counter equals X and line counter equals Y.
// R5: Dual scan: start address, wrap address at upper height carry, back again.
// R6: No cursor pixels below the last active screen line.
// R7: No cursor pixels right of the last active pixel of a line.
// R8: New vertical position is used only from the next frame.
// R9: New horizontal position used from next frame; also upper half start.
// R10: Lower half vertical position starts lower cursor, takes effect next frame.
// R11: Cursor blink, 50% duty, period a programmable count of frames.
// R12: In blink phase, blink colours replace first and second colours.
// R13: Two-bit stride code selects 1 to 4 words between image lines.
// R14: Six-bit height field holds lines minus one; upper half only in dual scan.
// R15: Two-bit width code selects 1 to 4 words shown per line.
// R16: Six-bit lower height field used only when dual scan is selected.
// R17: First colour register for code 2, second colour register for code 3.
// R18: Enable bit in position register turns overlay on; clear means no overlay.
// R19: Software sets wrap address equal to start and positions within active area.
// R20: Width below stride with offset start shows the right part of a wider image.
// R21: Software should not toggle enable while changing bitmaps.
// R22: Pending position changes take effect at the end-of-frame point.
// R23: Reset clears the enable bit.
package hco_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] OFS_START = 8'h00;
  localparam logic [7:0] OFS_WRAP = 8'h04;
  localparam logic [7:0] OFS_DIM = 8'h08;
  localparam logic [7:0] OFS_COL1 = 8'h0C;
  localparam logic [7:0] OFS_COL2 = 8'h10;
  localparam logic [7:0] OFS_POS = 8'h14;
  localparam logic [7:0] OFS_LOWY = 8'h18;
  localparam logic [7:0] OFS_BCOL1 = 8'h1C;
  localparam logic [7:0] OFS_BCOL2 = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_STAT = 8'h28;
  // Field positions
  localparam int STRIDE_LSB = 0;
  localparam int UPPER_H_LSB = 2;
  localparam int WIDTH_LSB = 8;
  localparam int LOWER_H_LSB = 10;
  localparam int POSX_LSB = 0;
  localparam int POSY_LSB = 16;
  localparam int ENABLE_BIT = 31;
  localparam int DUAL_BIT = 0;
  localparam int BLINK_EN_BIT = 1;
  localparam int BLINK_HALF_LSB = 8;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0] RST_BLINK_HALF = 8'h10;
  // Pixel codes
  localparam logic [1:0] CODE_CLEAR = 2'h0;
  localparam logic [1:0] CODE_INVERT = 2'h1;
  localparam logic [1:0] CODE_COL1 = 2'h2;
  localparam logic [1:0] CODE_COL2 = 2'h3;
  localparam int PIX_PER_WORD = 16;
  localparam int WORD_BYTES = 4;

  typedef enum logic [2:0] {
    PH_UP_WAIT = 3'b000,
    PH_UP_DRAW = 3'b001,
    PH_LO_WAIT = 3'b010,
    PH_LO_DRAW = 3'b011,
    PH_DONE = 3'b100
  } hco_phase_t;

  typedef enum logic [1:0] {
    FT_IDLE = 2'b00,
    FT_REQ = 2'b01
  } hco_fetch_t;

  // Video timing and pixel stream from the raster pipeline
  typedef struct packed {
    logic [10:0] hCount;
    logic [10:0] vCount;
    logic hActive;
    logic vActive;
    logic pixEn;
    logic lineEnd;
    logic frameEnd;
    logic [23:0] pixel;
  } hco_video_t;
endpackage

// file: design/hco_cursor.sv
// Hardware cursor overlay: APB registers, image fetch master and pixel mux
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module hco_cursor
  import hco_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Image fetch master
  output logic memReq,
  output logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic [31:0] memData,
  // Video stream in and out
  input wire hco_video_t vidIn,
  output logic [23:0] pixelOut,
  output logic pixelOutValid
);
  logic [31:0] start_reg, wrap_reg, dim_reg, col1_reg, col2_reg, pos_reg, lowY_reg;
  logic [31:0] bcol1_reg, bcol2_reg, ctrl_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg, ackPend_reg;
  logic [10:0] xLat_reg, yLat_reg, lowYLat_reg;
  hco_phase_t phase_reg;
  hco_fetch_t fetch_reg;
  logic [5:0] lineCnt_reg;
  logic [31:0] ptr_reg;
  logic [1:0] wordIdx_reg;
  logic [31:0] lineBuf [0:3];
  logic running_reg;
  logic [5:0] pixIdx_reg;
  logic [7:0] blinkCnt_reg;
  logic blinkPhase_reg;
  logic [23:0] pixelOut_reg;
  logic outValid_reg;

  // APB decode
  wire setup = psel & ~penable;
  wire wrAccess = psel & penable & pwrite;
  wire hitStart = paddr == OFS_START;
  wire hitWrap = paddr == OFS_WRAP;
  wire hitDim = paddr == OFS_DIM;
  wire hitCol1 = paddr == OFS_COL1;
  wire hitCol2 = paddr == OFS_COL2;
  wire hitPos = paddr == OFS_POS;
  wire hitLowY = paddr == OFS_LOWY;
  wire hitBcol1 = paddr == OFS_BCOL1;
  wire hitBcol2 = paddr == OFS_BCOL2;
  wire hitCtrl = paddr == OFS_CTRL;
  wire hitStat = paddr == OFS_STAT;
  wire hitAny = hitStart | hitWrap | hitDim | hitCol1 | hitCol2 | hitPos | hitLowY | hitBcol1 | hitBcol2
    | hitCtrl | hitStat;
  wire [31:0] statusWord = {22'h0, blinkPhase_reg, running_reg, lineCnt_reg, phase_reg == PH_LO_DRAW,
    phase_reg == PH_UP_DRAW};
  wire [31:0] readMux = hitStart ? start_reg : hitWrap ? wrap_reg : hitDim ? dim_reg : hitCol1 ? col1_reg :
    hitCol2 ? col2_reg : hitPos ? pos_reg : hitLowY ? lowY_reg : hitBcol1 ? bcol1_reg :
    hitBcol2 ? bcol2_reg : hitCtrl ? ctrl_reg : hitStat ? statusWord : 32'h0000_0000;
  assign pready = psel & penable & ackPend_reg;
  assign prdata = prdata_reg;
  assign pslverr = pready & slverr_reg;
  wire doWrite = wrAccess & ackPend_reg & ~slverr_reg;

  // Configuration fields
  // R13 stride code
  wire [1:0] strideCode = dim_reg[STRIDE_LSB +: 2];
  // R14 upper height
  wire [5:0] upperLines = dim_reg[UPPER_H_LSB +: 6];
  // R15 width code
  wire [1:0] widthCode = dim_reg[WIDTH_LSB +: 2];
  // R16 lower height
  wire [5:0] lowerLines = dim_reg[LOWER_H_LSB +: 6];
  wire dualScan = ctrl_reg[DUAL_BIT];
  wire blinkEn = ctrl_reg[BLINK_EN_BIT];
  wire [7:0] blinkHalf = ctrl_reg[BLINK_HALF_LSB +: 8];
  // R18 enable bit
  wire overlayOn = pos_reg[ENABLE_BIT];
  wire [31:0] strideBytes = 32'({strideCode, 2'b00}) + 32'(WORD_BYTES);
  wire [10:0] nextLine = vidIn.vCount + 11'h001;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ackPend_reg <= 1'b0;
      slverr_reg <= 1'b0;
      prdata_reg <= RST_ZERO;
    end else begin
      ackPend_reg <= setup;
      if (setup) begin
        slverr_reg <= ~hitAny | (pwrite & hitStat);
        prdata_reg <= pwrite ? RST_ZERO : readMux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      start_reg <= RST_ZERO;
      wrap_reg <= RST_ZERO;
      dim_reg <= RST_ZERO;
      col1_reg <= RST_ZERO;
      col2_reg <= RST_ZERO;
      // R23 enable cleared
      pos_reg <= RST_ZERO;
      lowY_reg <= RST_ZERO;
      bcol1_reg <= RST_ZERO;
      bcol2_reg <= RST_ZERO;
      ctrl_reg <= {16'h0000, RST_BLINK_HALF, 8'h00};
    end else if (doWrite) begin
      if (hitStart) start_reg <= pwdata;
      if (hitWrap) wrap_reg <= pwdata;
      if (hitDim) dim_reg <= {16'h0000, pwdata[15:0]};
      if (hitCol1) col1_reg <= {8'h00, pwdata[23:0]};
      if (hitCol2) col2_reg <= {8'h00, pwdata[23:0]};
      if (hitPos) pos_reg <= {pwdata[31], 4'h0, pwdata[26:16], 5'h00, pwdata[10:0]};
      if (hitLowY) lowY_reg <= {21'h000000, pwdata[10:0]};
      if (hitBcol1) bcol1_reg <= {8'h00, pwdata[23:0]};
      if (hitBcol2) bcol2_reg <= {8'h00, pwdata[23:0]};
      if (hitCtrl) ctrl_reg <= {16'h0000, pwdata[15:8], 6'h00, pwdata[1:0]};
    end
  end

  // Positions are shadowed so a write mid-frame cannot tear the cursor
  always_ff @(posedge mclk) begin
    if (rst) begin
      xLat_reg <= 11'h000;
      yLat_reg <= 11'h000;
      lowYLat_reg <= 11'h000;
    end else if (vidIn.frameEnd) begin
      // R22 apply at end of frame
      // R8 vertical from next frame
      yLat_reg <= pos_reg[POSY_LSB +: 11];
      // R9 horizontal from next frame
      xLat_reg <= pos_reg[POSX_LSB +: 11];
      // R10 lower half from next frame
      lowYLat_reg <= lowY_reg[10:0];
    end
  end

  // R11 blink half period in frames
  always_ff @(posedge mclk) begin
    if (rst) begin
      blinkCnt_reg <= 8'h00;
      blinkPhase_reg <= 1'b0;
    end else if (!blinkEn) begin
      blinkCnt_reg <= 8'h00;
      blinkPhase_reg <= 1'b0;
    end else if (vidIn.frameEnd) begin
      if (blinkCnt_reg >= blinkHalf) begin
        blinkCnt_reg <= 8'h00;
        blinkPhase_reg <= ~blinkPhase_reg;
      end else begin
        blinkCnt_reg <= blinkCnt_reg + 8'h01;
      end
    end
  end

  // Line sequencing: one decision at each line end for the line that follows
  wire startUpper = phase_reg == PH_UP_WAIT && nextLine == yLat_reg;
  wire startLower = phase_reg == PH_LO_WAIT && nextLine == lowYLat_reg;
  wire drawing = phase_reg == PH_UP_DRAW || phase_reg == PH_LO_DRAW;
  wire [5:0] heightLim = phase_reg == PH_LO_DRAW ? lowerLines : upperLines;
  wire heightCarry = drawing && lineCnt_reg == heightLim;
  wire fetchKick = vidIn.lineEnd && overlayOn && (startUpper || startLower || (drawing && !heightCarry));

  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_reg <= PH_DONE;
      lineCnt_reg <= 6'h00;
      ptr_reg <= RST_ZERO;
    end else if (vidIn.frameEnd) begin
      // R5 each frame opens at the start address
      phase_reg <= PH_UP_WAIT;
      lineCnt_reg <= 6'h00;
      ptr_reg <= start_reg;
    end else if (vidIn.lineEnd) begin
      case (phase_reg)
        // R4 vertical match
        PH_UP_WAIT: if (startUpper) phase_reg <= PH_UP_DRAW;
        PH_LO_WAIT: if (startLower) phase_reg <= PH_LO_DRAW;
        PH_UP_DRAW, PH_LO_DRAW: begin
          if (heightCarry) begin
            lineCnt_reg <= 6'h00;
            // R5 jump between halves on height carry
            if (phase_reg == PH_UP_DRAW && dualScan) begin
              ptr_reg <= wrap_reg;
              phase_reg <= PH_LO_WAIT;
            end else begin
              ptr_reg <= phase_reg == PH_LO_DRAW ? start_reg : wrap_reg;
              phase_reg <= PH_DONE;
            end
          end else begin
            lineCnt_reg <= lineCnt_reg + 6'h01;
            // R13 advance by stride
            ptr_reg <= ptr_reg + strideBytes;
          end
        end
        default: phase_reg <= phase_reg;
      endcase
    end
  end

  // Fetch address for the first line of a half is the pointer itself, later lines add the stride
  logic [31:0] lineBase_reg;
  wire [31:0] kickBase = (startUpper || startLower) ? ptr_reg : ptr_reg + strideBytes;

  // R3 own bus master, one line per fetch
  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_reg <= FT_IDLE;
      wordIdx_reg <= 2'h0;
      lineBase_reg <= RST_ZERO;
    end else begin
      case (fetch_reg)
        FT_IDLE: begin
          if (fetchKick) begin
            fetch_reg <= FT_REQ;
            wordIdx_reg <= 2'h0;
            lineBase_reg <= kickBase;
          end
        end
        FT_REQ: begin
          if (memAck) begin
            // R20 only the width words are fetched and shown
            if (wordIdx_reg == widthCode) fetch_reg <= FT_IDLE;
            wordIdx_reg <= wordIdx_reg + 2'h1;
          end
        end
        default: fetch_reg <= FT_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (fetch_reg == FT_REQ && memAck) lineBuf[wordIdx_reg] <= memData;
  end

  assign memReq = fetch_reg == FT_REQ;
  assign memAddr = lineBase_reg + {28'h0000000, wordIdx_reg, 2'b00};

  // Horizontal run across the current cursor line
  wire visible = vidIn.hActive && vidIn.vActive;
  wire [5:0] lastPix = {widthCode, 4'hF};
  wire runStart = drawing && overlayOn && vidIn.pixEn && vidIn.hCount == xLat_reg;
  wire inRun = running_reg || runStart;
  wire [5:0] curIdx = runStart ? 6'h00 : pixIdx_reg;
  wire [31:0] curWord = lineBuf[curIdx[5:4]];
  // R2 pixel n at bits 2n+1:2n
  wire [1:0] code = curWord[{curIdx[3:0], 1'b0} +: 2];

  always_ff @(posedge mclk) begin
    if (rst) begin
      running_reg <= 1'b0;
      pixIdx_reg <= 6'h00;
    end else if (vidIn.lineEnd || !overlayOn) begin
      running_reg <= 1'b0;
      pixIdx_reg <= 6'h00;
    end else if (vidIn.pixEn && inRun) begin
      // R15 run length from width
      running_reg <= curIdx != lastPix;
      pixIdx_reg <= curIdx + 6'h01;
    end
  end

  // R12 blink colours swap in
  wire [23:0] colA = blinkPhase_reg ? bcol1_reg[23:0] : col1_reg[23:0];
  wire [23:0] colB = blinkPhase_reg ? bcol2_reg[23:0] : col2_reg[23:0];
  logic [23:0] mixed;
  always_comb begin
    mixed = vidIn.pixel;
    // R6 bottom clip and R7 right clip via active window
    if (inRun && visible && overlayOn) begin
      // R1 code decode
      case (code)
        CODE_CLEAR: mixed = vidIn.pixel;
        CODE_INVERT: mixed = ~vidIn.pixel;
        // R17 colour registers per code
        CODE_COL1: mixed = colA;
        CODE_COL2: mixed = colB;
        default: mixed = vidIn.pixel;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pixelOut_reg <= 24'h000000;
      outValid_reg <= 1'b0;
    end else begin
      outValid_reg <= vidIn.pixEn;
      if (vidIn.pixEn) pixelOut_reg <= mixed;
    end
  end

  assign pixelOut = pixelOut_reg;
  assign pixelOutValid = outValid_reg;
endmodule

// file: sim/hco_cursor_properties.sv
// Port-level checks for the cursor overlay
`timescale 1ns/10ps
module hco_cursor_properties
  import hco_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Fetch master
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic [31:0] memData,
  // Video
  input wire hco_video_t vidIn,
  input wire logic [23:0] pixelOut,
  input wire logic pixelOutValid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_wait; memReq && !memAck; endsequence
  chk_apb_zero_wait: assert property (s_setup ##1 s_access |-> pready)
    else $error("pready late");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_unmapped: assert property (psel && penable && pready && paddr > OFS_STAT |-> pslverr)
    else $error("unmapped access accepted");
  chk_err_status_write: assert property (psel && penable && pready && pwrite && paddr == OFS_STAT |-> pslverr)
    else $error("status write accepted");
  chk_valid_delay: assert property (pixelOutValid == $past(vidIn.pixEn))
    else $error("pixelOutValid not one cycle after pixEn");
  chk_out_holds: assert property (!vidIn.pixEn |=> $stable(pixelOut))
    else $error("pixelOut moved without pixEn");
  chk_clip_passthrough: assert property (
    vidIn.pixEn && !(vidIn.hActive && vidIn.vActive) |=> pixelOut == $past(vidIn.pixel))
    else $error("overlay outside active area");
  chk_fetch_hold: assert property (s_wait |=> memReq && $stable(memAddr))
    else $error("fetch request dropped or moved");
  chk_fetch_step: assert property (memReq && memAck ##1 memReq |-> memAddr == $past(memAddr) + 32'h4)
    else $error("fetch address did not step a word");
endmodule

bind hco_cursor hco_cursor_properties u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData), .vidIn(vidIn),
  .pixelOut(pixelOut), .pixelOutValid(pixelOutValid));

// file: sim/hco_mem_model.sv
// Behavioural image memory behind the fetch master
`timescale 1ns/10ps
module hco_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fetch port
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  output logic memAck,
  output logic [31:0] memData,
  // Extra answer delay
  input wire logic [1:0] slowCycles
);
  logic [1:0] waitCnt;
  always_ff @(posedge mclk) begin
    if (rst) begin
      memAck <= 1'b0;
      memData <= 32'h0;
      waitCnt <= 2'h0;
    end else if (memReq && !memAck && waitCnt >= slowCycles) begin
      memAck <= 1'b1;
      memData <= 32'h1B1B_1B1B;
      waitCnt <= 2'h0;
    end else begin
      memAck <= 1'b0;
      // Off-ack data keeps changing so a stale latch shows
      memData <= memData + 32'h1111_1111;
      waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
    end
  end
endmodule

// file: sim/test_hardware_cursor_overlay.sv
// Self-checking bench for the cursor overlay
`timescale 1ns/10ps
module test_hardware_cursor_overlay;
  import hco_pkg::*;
  localparam logic [23:0] BG = 24'h35A6C9;
  localparam logic [31:0] START = 32'h0000_4A40;
  localparam logic [31:0] WRAP = 32'h0000_4B40;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] slowCycles = 2'h0;
  hco_video_t vidIn = '0;
  logic [31:0] prdata, memAddr, memData, rdData;
  logic pready, pslverr, memReq, memAck, pixelOutValid, rdErr, curEn;
  logic [23:0] pixelOut;
  logic [31:0] ackAddr[$];
  int fails = 0;
  int n_compared = 0;
  int curX, curY, nextX, nextY;
  int lowLine = -1;
  logic [23:0] expC1 = 24'h112233;
  logic [23:0] expC2 = 24'h445566;
  hco_cursor u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .memData(memData), .vidIn(vidIn), .pixelOut(pixelOut),
    .pixelOutValid(pixelOutValid));
  hco_mem_model u_mem (.mclk(mclk), .rst(rst), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memData(memData), .slowCycles(slowCycles));
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (memReq === 1'b1 && memAck === 1'b1) ackAddr.push_back(memAddr);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a hung access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_pos(input logic en, input int x, input int y);
    apb(1'b1, OFS_POS, {en, 4'h0, 11'(y), 5'h00, 11'(x)});
    nextX = x;
    nextY = y;
    curEn = en;
  endtask
  task automatic video_line(input int v);
    int k;
    logic [23:0] e;
    for (int h = 0; h <= 28; h++) begin
      @(posedge mclk);
      vidIn.hCount <= 11'(h);
      vidIn.vCount <= 11'(v);
      vidIn.hActive <= (h < 24);
      vidIn.vActive <= 1'b1;
      vidIn.pixEn <= (h < 28);
      vidIn.pixel <= BG;
      @(negedge mclk);
      k = h - 1 - curX;
      e = BG;
      if (curEn && (v >= curY && v <= curY + 1 || v == lowLine) && k >= 0 && k < 16 && h < 25)
        case (3 - k % 4)
          1: e = ~BG;
          2: e = expC1;
          3: e = expC2;
          default: e = BG;
        endcase
      if (h > 0) cmp({8'h00, pixelOut}, {8'h00, e});
    end
    @(posedge mclk);
    vidIn.lineEnd <= 1'b1;
    @(posedge mclk);
    vidIn.lineEnd <= 1'b0;
    repeat (20) @(posedge mclk);
  endtask
  task automatic video_frame(input bit move, input int nFetch);
    @(posedge mclk);
    vidIn.frameEnd <= 1'b1;
    @(posedge mclk);
    vidIn.frameEnd <= 1'b0;
    curX = nextX;
    curY = nextY;
    ackAddr.delete();
    for (int v = 0; v < 5; v++) begin
      video_line(v);
      if (move && v == 0) set_pos(1'b1, 4, 1);
    end
    cmp(32'(ackAddr.size()), 32'(nFetch));
    if (nFetch > 0) begin
      cmp(ackAddr[0], START);
      cmp(ackAddr[1], START + 32'h8);
    end
  endtask
  task automatic t_regs();
    apb(1'b0, OFS_POS, 32'h0);
    cmp(rdData, RST_ZERO);
    apb(1'b0, OFS_CTRL, 32'h0);
    cmp(rdData, {16'h0000, RST_BLINK_HALF, 8'h00});
    apb(1'b0, 8'h2C, 32'h0);
    cmp(rdData, 32'h0000_0000);
    cmp({31'h0, rdErr}, 32'h0000_0001);
    apb(1'b1, OFS_STAT, 32'hFFFF_FFFF);
    cmp({31'h0, rdErr}, 32'h1);
    apb(1'b1, OFS_START, START);
    apb(1'b1, OFS_WRAP, START);
    apb(1'b1, OFS_DIM, 32'h0000_0005);
    apb(1'b1, OFS_COL1, 32'h0011_2233);
    apb(1'b1, OFS_COL2, 32'h0044_5566);
    apb(1'b0, OFS_DIM, 32'h0);
    cmp(rdData, 32'h0000_0005);
    $display("test regs done");
  endtask
  task automatic t_overlay();
    set_pos(1'b1, 12, 2);
    video_frame(1'b0, 2);
    video_frame(1'b1, 2);
    slowCycles <= 2'h3;
    video_frame(1'b0, 2);
    $display("test overlay done");
  endtask
  task automatic t_dual();
    apb(1'b1, OFS_WRAP, WRAP);
    apb(1'b1, OFS_LOWY, 32'h0000_0004);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    lowLine = 4;
    video_frame(1'b0, 3);
    cmp(ackAddr[2], WRAP);
    lowLine = -1;
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_WRAP, START);
    $display("test dual done");
  endtask
  task automatic t_blink();
    apb(1'b1, OFS_BCOL1, 32'h00AA_BBCC);
    apb(1'b1, OFS_BCOL2, 32'h00DD_EEFF);
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    expC1 = 24'hAABBCC;
    expC2 = 24'hDDEEFF;
    video_frame(1'b0, 2);
    expC1 = 24'h112233;
    expC2 = 24'h445566;
    video_frame(1'b0, 2);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    $display("test blink done");
  endtask
  task automatic t_disable();
    set_pos(1'b0, 12, 2);
    video_frame(1'b0, 0);
    $display("test disable done");
  endtask
  task automatic finish_test();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    curEn = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_overlay();
    t_dual();
    t_blink();
    t_disable();
    finish_test();
  end
  initial begin
    #500000;
    fails++;
    finish_test();
  end
endmodule
